// >>> common/e1n_pkg.sv
// constants for the timeslot-zero national bit and data link block
package e1n_pkg;
  // register port: address bit 4 low selects the page register
  localparam logic [4:0] ADDR_PAGE_BIT  = 5'h10;
  localparam logic [7:0] PAGE_MASTER_CTL = 8'h01;
  localparam logic [7:0] PAGE_MASTER_STS = 8'h03;
  localparam logic [7:0] PAGE_TX_NATBITS = 8'h0D;
  localparam logic [7:0] PAGE_RX_NATBITS = 8'h0E;
  // offsets within a page
  localparam logic [4:0] OFS_LINK_SEL    = 5'h10;
  localparam logic [4:0] OFS_CH0_TRANSP  = 5'h17;
  localparam logic [4:0] OFS_SA_CHG_CTL  = 5'h19;
  localparam logic [4:0] OFS_IRQ_MASK    = 5'h1D;
  localparam logic [4:0] OFS_MF_STATUS   = 5'h12;
  localparam logic [4:0] OFS_IRQ_STATUS  = 5'h13;
  localparam logic [4:0] OFS_NATBITS_0   = 5'h10;
  // sticky status bit positions
  localparam int unsigned STS_MF_START  = 0;
  localparam int unsigned STS_SA_BIT    = 1;
  localparam int unsigned STS_SA_NIBBLE = 2;
  // reset values
  localparam logic [7:0] RST_PAGE     = 8'h00;
  localparam logic [7:0] RST_SELECT   = 8'h00;
  localparam logic [7:0] RST_NATBITS  = 8'hFF;
  localparam logic [7:0] RST_IRQ_MASK = 8'h00;
  // frame layout
  localparam logic [7:0] FAS_WORD  = 8'h9B;
  localparam logic [7:0] MFAS_BITS = 8'h2F;
  localparam logic       ALARM_BIT = 1'b0;
  localparam int unsigned NUM_SA   = 5;
  localparam logic [2:0] SA4_BIT   = 3'h3;
  // timing
  localparam int unsigned CLK_MHZ      = 100;
  localparam int unsigned LINK_PULSE_NS = 244;
  localparam int unsigned LINK_PULSE_CYC = (LINK_PULSE_NS * CLK_MHZ) / 1000;
  localparam int unsigned SYNC_LAT_CYC = 3;
  localparam int unsigned FIFO_DEPTH   = 32;
endpackage : e1n_pkg

// >>> hw/e1n_natbits.sv
// timeslot-zero national bits, sa data link and fifo, with sync and fifo helpers
`timescale 1ns/100ps

// three-stage pin synchroniser; output moves once stages two and three agree
module e1n_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             i_clk,
  input  wire logic             i_sys_rst,
  input  wire logic [WIDTH-1:0] i_pin,
  input  wire logic [WIDTH-1:0] i_rst_val,
  output logic      [WIDTH-1:0] o_level
);
  logic [WIDTH-1:0] s1_ff;
  logic [WIDTH-1:0] s2_ff;
  logic [WIDTH-1:0] s3_ff;
  wire  [WIDTH-1:0] nxt_level = (s2_ff ~^ s3_ff) & s3_ff | (s2_ff ^ s3_ff) & o_level;

  // reset value is a constant from the instance, never a pin
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      s1_ff   <= i_rst_val;
      s2_ff   <= i_rst_val;
      s3_ff   <= i_rst_val;
      o_level <= i_rst_val;
    end
    else
    begin
      s1_ff   <= i_pin;
      s2_ff   <= s1_ff;
      s3_ff   <= s2_ff;
      o_level <= nxt_level;
    end
  end
endmodule : e1n_sync

// first-word-fall-through fifo, flip-flop storage
module e1n_fifo #(
  parameter int unsigned WIDTH = 1,
  parameter int unsigned DEPTH = 32
) (
  input  wire logic             i_clk,
  input  wire logic             i_sys_rst,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW:0]      wr_ff;
  logic [AW:0]      rd_ff;
  wire              full  = (wr_ff[AW] != rd_ff[AW]) && (wr_ff[AW-1:0] == rd_ff[AW-1:0]);
  wire              empty = (wr_ff == rd_ff);
  wire              push  = i_in_valid && !full;
  wire              pop   = i_out_ready && !empty;

  assign o_in_ready  = !full;
  assign o_out_valid = !empty;
  assign o_out_data  = mem_ff[rd_ff[AW-1:0]];

  // pointers carry a wrap bit so full and empty stay exact
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      wr_ff <= '0;
      rd_ff <= '0;
    end
    else
    begin
      if (push)
        wr_ff <= wr_ff + (AW+1)'(1);
      if (pop)
        rd_ff <= rd_ff + (AW+1)'(1);
    end
  end

  // storage has no reset; only written words are ever read
  always_ff @(posedge i_clk)
  begin
    if (push)
      mem_ff[wr_ff[AW-1:0]] <= i_in_data;
  end
endmodule : e1n_fifo

module e1n_natbits
  import e1n_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_sys_rst,
  // paged register port
  input  wire logic       i_cs,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  input  wire logic [4:0] i_addr,
  input  wire logic [7:0] i_wdata,
  output logic      [7:0] o_rdata,
  // pins
  input  wire logic       i_force_all_ones_n,
  output logic            o_irq_n_out,
  output logic            o_irq_n_oe,
  // transmit timebase and streams (same clock)
  input  wire logic       i_tx_bit_strobe,
  input  wire logic       i_backplane_data_in,
  output logic            o_tx_line_data,
  // transmit data link
  input  wire logic       i_tx_link_data_in,
  output logic            o_tx_link_clock_out,
  // receive line from the clock extractor and aligner (pins)
  input  wire logic       i_rx_line_clk,
  input  wire logic       i_rx_line_data,
  input  wire logic       i_rx_mf_sync,
  output logic            o_rx_link_data_out,
  output logic            o_rx_link_clock_out
);
  // ---------------- pin synchronisers ----------------
  logic [4:0] pin_lvl;
  wire        ais_n_s   = pin_lvl[0];
  wire        tlk_pin_s = pin_lvl[1];
  wire        rclk_s    = pin_lvl[2];
  wire        rdata_s   = pin_lvl[3];
  wire        rmf_s     = pin_lvl[4];

  e1n_sync #(.WIDTH(5)) u_sync (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_pin     ({i_rx_mf_sync, i_rx_line_data, i_rx_line_clk, i_tx_link_data_in,
                 i_force_all_ones_n}),
    .i_rst_val (5'h00),
    .o_level   (pin_lvl)
  );

  // ---------------- registers ----------------
  logic [7:0] page_ff;
  logic [7:0] lnk_sel_ff;
  logic [7:0] tr_sel_ff;
  logic [7:0] chg_ctl_ff;
  logic [7:0] irq_mask_ff;
  logic [2:0] irq_sts_ff;
  logic [7:0] tx_nb_ff [NUM_SA];
  logic [7:0] rx_nb_ff [NUM_SA];
  logic       mf_sts_ff;

  // page select first, then offset within the page
  wire        acc_page = i_cs && !i_addr[4];
  wire        acc_reg  = i_cs && i_addr[4];
  wire        on_ctl   = (page_ff == PAGE_MASTER_CTL);
  wire        on_sts   = (page_ff == PAGE_MASTER_STS);
  wire        on_txnb  = (page_ff == PAGE_TX_NATBITS);
  wire        on_rxnb  = (page_ff == PAGE_RX_NATBITS);
  wire [4:0]  nb_ofs   = i_addr - OFS_NATBITS_0;
  wire        nb_hit   = (i_addr >= OFS_NATBITS_0) && (nb_ofs < 5'(NUM_SA));
  wire [2:0]  nb_idx   = nb_ofs[2:0];
  wire        wr_page  = acc_page && i_wr;
  wire        wr_lnsel = acc_reg && i_wr && on_ctl && (i_addr == OFS_LINK_SEL);
  wire        wr_trsel = acc_reg && i_wr && on_ctl && (i_addr == OFS_CH0_TRANSP);
  wire        wr_chg   = acc_reg && i_wr && on_ctl && (i_addr == OFS_SA_CHG_CTL);
  wire        wr_mask  = acc_reg && i_wr && on_ctl && (i_addr == OFS_IRQ_MASK);
  wire        wr_txnb  = acc_reg && i_wr && on_txnb && nb_hit;
  wire        rd_sts   = acc_reg && i_rd && on_sts && (i_addr == OFS_IRQ_STATUS);
  wire [4:0]  lnk_sel  = lnk_sel_ff[4:0];
  wire [4:0]  tr_sel   = tr_sel_ff[4:0];

  // read mux; unmapped offsets read zero
  logic [7:0] rd_mux;
  always_comb
  begin
    rd_mux = 8'h00;
    if (acc_page)
      rd_mux = page_ff;
    else if (on_ctl && i_addr == OFS_LINK_SEL)
      rd_mux = {3'h0, lnk_sel};
    else if (on_ctl && i_addr == OFS_CH0_TRANSP)
      rd_mux = {3'h0, tr_sel};
    else if (on_ctl && i_addr == OFS_SA_CHG_CTL)
      rd_mux = chg_ctl_ff;
    else if (on_ctl && i_addr == OFS_IRQ_MASK)
      rd_mux = {5'h00, irq_mask_ff[2:0]};
    else if (on_sts && i_addr == OFS_MF_STATUS)
      rd_mux = {7'h00, mf_sts_ff};
    else if (on_sts && i_addr == OFS_IRQ_STATUS)
      rd_mux = {5'h00, irq_sts_ff};
    else if (on_txnb && nb_hit)
      rd_mux = tx_nb_ff[nb_idx];
    else if (on_rxnb && nb_hit)
      rd_mux = rx_nb_ff[nb_idx];
  end

  // control registers and read data
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      page_ff     <= RST_PAGE;
      lnk_sel_ff  <= RST_SELECT;
      tr_sel_ff   <= RST_SELECT;
      chg_ctl_ff  <= RST_SELECT;
      irq_mask_ff <= RST_IRQ_MASK;
      o_rdata     <= 8'h00;
    end
    else
    begin
      if (wr_page)
        page_ff <= i_wdata;
      if (wr_lnsel)
        lnk_sel_ff <= {3'h0, i_wdata[4:0]};
      if (wr_trsel)
        tr_sel_ff <= {3'h0, i_wdata[4:0]};
      if (wr_chg)
        chg_ctl_ff <= i_wdata;
      if (wr_mask)
        irq_mask_ff <= {5'h00, i_wdata[2:0]};
      if (acc_page || acc_reg)
        o_rdata <= rd_mux;
    end
  end

  // transmit buffer: byte per sa bit, frame 1 in msb
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      for (int i = 0; i < NUM_SA; i++)
        tx_nb_ff[i] <= RST_NATBITS;
    else if (wr_txnb)
      tx_nb_ff[nb_idx] <= i_wdata;
  end

  // ---------------- transmit framing ----------------
  logic [11:0] tx_pos_ff;                      // frame[11:8], bit[7:0]
  wire  [3:0]  tx_frm  = tx_pos_ff[11:8];
  wire  [2:0]  tx_bi   = tx_pos_ff[2:0];       // 0 is channel bit 1, the msb
  wire         tx_ts0  = (tx_pos_ff[7:3] == 5'h00);
  wire         tx_odd  = tx_frm[0];
  wire  [2:0]  tx_k    = tx_frm[3:1];          // odd frame index 0..7
  wire         tx_sa   = tx_ts0 && (tx_bi >= SA4_BIT);
  wire  [2:0]  tx_row  = tx_bi - SA4_BIT;      // 0 is sa4
  wire  [2:0]  tx_selb = 3'h4 - tx_row;        // select field bit 4 is sa4
  wire         tx_lnk  = tx_sa && lnk_sel[tx_selb];
  wire         tx_tr   = tx_sa && tr_sel[tx_selb];
  wire         fifo_in_ready;
  wire         fifo_out_valid;
  wire         fifo_out_data;
  wire         fifo_pop = i_tx_bit_strobe && tx_odd && tx_lnk;

  // timeslot-zero bit chooser; link beats transparency beats buffer
  logic tx_ts0_bit;
  always_comb
  begin
    tx_ts0_bit = 1'b1;
    if (!tx_odd)
      tx_ts0_bit = FAS_WORD[3'h7 - tx_bi];
    else if (tx_bi == 3'h0)
      tx_ts0_bit = MFAS_BITS[3'h7 - tx_k];
    else if (tx_bi == 3'h1)
      tx_ts0_bit = 1'b1;
    else if (tx_bi == 3'h2)
      tx_ts0_bit = ALARM_BIT;
    else if (tx_lnk)
      tx_ts0_bit = fifo_out_valid ? fifo_out_data : 1'b1;
    else if (tx_tr)
      tx_ts0_bit = i_backplane_data_in;
    else
      tx_ts0_bit = tx_nb_ff[tx_row][3'h7 - tx_k];
  end

  wire nxt_tx_line = !ais_n_s ? 1'b1 : (tx_ts0 ? tx_ts0_bit : i_backplane_data_in);

  // line bit and position advance on each timebase strobe
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      tx_pos_ff      <= 12'h000;
      o_tx_line_data <= 1'b1;
    end
    else if (i_tx_bit_strobe)
    begin
      tx_pos_ff      <= tx_pos_ff + 12'h001;
      o_tx_line_data <= nxt_tx_line;
    end
  end

  // ---------------- transmit data link clock ----------------
  // bits are fetched one frame early, in the fas frame's sa bit times, so
  // each is queued before its nfas slot; a full queue withholds the pulse
  logic [7:0] tlk_cnt_ff;
  wire        tlk_start = i_tx_bit_strobe && !tx_odd && tx_lnk && fifo_in_ready;
  wire        tlk_take  = (tlk_cnt_ff == 8'(LINK_PULSE_CYC - SYNC_LAT_CYC));

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      tlk_cnt_ff          <= 8'h00;
      o_tx_link_clock_out <= 1'b0;
    end
    else
    begin
      if (tlk_start)
        tlk_cnt_ff <= 8'(LINK_PULSE_CYC);
      else if (tlk_cnt_ff != 8'h00)
        tlk_cnt_ff <= tlk_cnt_ff - 8'h01;
      o_tx_link_clock_out <= tlk_start || (tlk_cnt_ff > 8'h01);
    end
  end

  // synchroniser delay means the captured level is the pin at the rising edge
  e1n_fifo #(.WIDTH(1), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_clk       (i_clk),
    .i_sys_rst   (i_sys_rst),
    .i_in_valid  (tlk_take),
    .o_in_ready  (fifo_in_ready),
    .i_in_data   (tlk_pin_s),
    .o_out_valid (fifo_out_valid),
    .i_out_ready (fifo_pop),
    .o_out_data  (fifo_out_data)
  );

  // ---------------- receive side ----------------
  logic        rclk_d_ff;
  logic [11:0] rx_pos_ff;
  logic [7:0]  rlk_cnt_ff;
  logic [7:0]  rx_asm_ff [NUM_SA];
  logic [NUM_SA-1:0] last_sa_ff;
  logic [3:0]  last_nib_ff [NUM_SA];
  wire         rx_rise  = rclk_s && !rclk_d_ff;
  wire  [11:0] nxt_rpos = rmf_s ? 12'h000 : rx_pos_ff + 12'h001;
  wire  [3:0]  rx_frm   = nxt_rpos[11:8];
  wire  [2:0]  rx_bi    = nxt_rpos[2:0];
  wire  [2:0]  rx_k     = rx_frm[3:1];
  wire  [2:0]  rx_row   = rx_bi - SA4_BIT;
  wire  [2:0]  rx_selb  = 3'h4 - rx_row;
  wire         rx_sa    = rx_rise && (nxt_rpos[7:3] == 5'h00) && rx_frm[0] && (rx_bi >= SA4_BIT);
  wire         rx_lnk   = rx_sa && lnk_sel[rx_selb];
  wire         rx_nib_end = (rx_k == 3'h3) || (rx_k == 3'h7);
  wire  [3:0]  rx_nib   = (rx_k == 3'h3) ? {rx_asm_ff[rx_row][7:5], rdata_s}
                                         : {rx_asm_ff[rx_row][3:1], rdata_s};
  wire         sa58     = rx_sa && (rx_row != 3'h0);
  wire         ev_bit   = sa58 && chg_ctl_ff[rx_row - 3'h1]
                          && (rdata_s != last_sa_ff[rx_row]);
  wire         ev_nib   = sa58 && rx_nib_end && chg_ctl_ff[3'h3 + rx_row]
                          && (rx_nib != last_nib_ff[rx_row]);
  wire         ev_mf    = rx_rise && rmf_s;
  wire  [2:0]  irq_set  = {ev_nib, ev_bit, ev_mf};
  wire         pend     = |(irq_sts_ff & irq_mask_ff[2:0]);

  // rx bit counter and link outputs; the link data is the synchronised receive
  // line bit, taken at each rising edge of the receive line clock
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      rclk_d_ff           <= 1'b0;
      rx_pos_ff           <= 12'h000;
      rlk_cnt_ff          <= 8'h00;
      mf_sts_ff           <= 1'b0;
      o_rx_link_data_out  <= 1'b1;
      o_rx_link_clock_out <= 1'b0;
    end
    else
    begin
      rclk_d_ff <= rclk_s;
      if (rx_rise)
      begin
        rx_pos_ff          <= nxt_rpos;
        o_rx_link_data_out <= rdata_s;
        mf_sts_ff          <= (rx_frm == 4'h0);
      end
      if (rx_lnk)
        rlk_cnt_ff <= 8'(LINK_PULSE_CYC);
      else if (rlk_cnt_ff != 8'h00)
        rlk_cnt_ff <= rlk_cnt_ff - 8'h01;
      o_rx_link_clock_out <= rx_lnk || (rlk_cnt_ff > 8'h01);
    end
  end

  // receive buffer assembly, committed row by row at each row's frame 15 bit
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      last_sa_ff <= '1;
      for (int i = 0; i < NUM_SA; i++)
      begin
        rx_asm_ff[i]   <= RST_NATBITS;
        rx_nb_ff[i]    <= RST_NATBITS;
        last_nib_ff[i] <= 4'hF;
      end
    end
    else if (rx_sa)
    begin
      rx_asm_ff[rx_row][3'h7 - rx_k] <= rdata_s;
      last_sa_ff[rx_row]             <= rdata_s;
      if (rx_nib_end)
        last_nib_ff[rx_row] <= rx_nib;
      if (rx_k == 3'h7)
        rx_nb_ff[rx_row] <= {rx_asm_ff[rx_row][7:1], rdata_s};
    end
  end

  // sticky events, cleared by reading; a new event in that cycle wins
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      irq_sts_ff <= 3'h0;
    else
      irq_sts_ff <= (rd_sts ? 3'h0 : irq_sts_ff) | irq_set;
  end

  // open-drain irq, released entirely while all-ones is forced
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      o_irq_n_out <= 1'b0;
      o_irq_n_oe  <= 1'b0;
    end
    else
    begin
      o_irq_n_out <= 1'b0;
      o_irq_n_oe  <= pend && ais_n_s;
    end
  end
endmodule : e1n_natbits

// >>> verif/e1n_link_ctl_model.sv
// behavioural external data link controller on the sa bit link pins
`timescale 1ns/100ps
module e1n_link_ctl_model (
  input  wire logic i_clk,
  input  wire logic i_sys_rst,
  input  wire logic i_clear,
  input  wire logic i_tx_link_clock_out,
  output logic      o_tx_link_data_in,
  input  wire logic i_rx_link_clock_out,
  input  wire logic i_rx_link_data_out,
  output int        o_rx_pulses,
  output int        o_rx_ones
);
  logic tx_clk_d_ff;
  logic rx_clk_d_ff;
  // tx bit flips after each pulse ends, so it is settled long before the next rise
  // rx bit is taken as the pulse starts; a stray pulse shows up as a one
  always_ff @(posedge i_clk)
  begin
    tx_clk_d_ff <= i_tx_link_clock_out;
    rx_clk_d_ff <= i_rx_link_clock_out;
    if (i_sys_rst)
      o_tx_link_data_in <= 1'b0;
    else if (tx_clk_d_ff && !i_tx_link_clock_out)
      o_tx_link_data_in <= ~o_tx_link_data_in;
    if (i_sys_rst || i_clear)
    begin
      o_rx_pulses <= 0;
      o_rx_ones <= 0;
    end
    else if (!rx_clk_d_ff && i_rx_link_clock_out)
    begin
      o_rx_pulses <= o_rx_pulses + 1;
      o_rx_ones <= o_rx_ones + int'(i_rx_link_data_out);
    end
  end
endmodule : e1n_link_ctl_model

// >>> verif/e1n_natbits_properties.sv
// port checker for the national bit block, bound to its top module
`timescale 1ns/100ps
module e1n_natbits_chk
  import e1n_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_sys_rst,
  input  wire logic       i_cs,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  input  wire logic [7:0] o_rdata,
  input  wire logic       i_force_all_ones_n,
  input  wire logic       o_irq_n_out,
  input  wire logic       o_irq_n_oe,
  input  wire logic       i_tx_bit_strobe,
  input  wire logic       o_tx_line_data,
  input  wire logic       o_tx_link_clock_out,
  input  wire logic       o_rx_link_clock_out
);
  logic       acc;
  logic [7:0] tx_cnt_ff;
  logic [7:0] rx_cnt_ff;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);
  assign acc = i_cs && (i_wr || i_rd);
  // high-cycle counters: a pulse is far longer than a repetition may be
  always_ff @(posedge i_clk)
  begin
    tx_cnt_ff <= (i_sys_rst || !o_tx_link_clock_out) ? 8'h00 : tx_cnt_ff + 8'h01;
    rx_cnt_ff <= (i_sys_rst || !o_rx_link_clock_out) ? 8'h00 : rx_cnt_ff + 8'h01;
  end
  chk_forced_line_ones: assert property (
    !i_force_all_ones_n [*6] ##0 i_tx_bit_strobe |=> o_tx_line_data)
    else $error("line bit not one while all ones forced");
  chk_irq_forced_off: assert property (
    !i_force_all_ones_n [*6] |-> !o_irq_n_oe)
    else $error("irq driven while all ones forced");
  chk_irq_pulls_low: assert property (
    o_irq_n_oe |-> !o_irq_n_out)
    else $error("irq drive value not low");
  chk_tx_pulse_width: assert property (
    $fell(o_tx_link_clock_out) |-> tx_cnt_ff == 8'(LINK_PULSE_CYC))
    else $error("tx link clock pulse width wrong");
  chk_rx_pulse_width: assert property (
    $fell(o_rx_link_clock_out) |-> rx_cnt_ff == 8'(LINK_PULSE_CYC))
    else $error("rx link clock pulse width wrong");
  chk_tx_clock_cause: assert property (
    $rose(o_tx_link_clock_out) |-> $past(i_tx_bit_strobe))
    else $error("tx link clock rose without a bit strobe");
  chk_rdata_hold: assert property (
    !acc [*3] |-> $stable(o_rdata))
    else $error("read data moved without an access");
  chk_line_bit_hold: assert property (
    !i_tx_bit_strobe [*3] |-> $stable(o_tx_line_data))
    else $error("line bit moved without a strobe");
  cov_tx_pulse: cover property ($rose(o_tx_link_clock_out));
  cov_rx_pulse: cover property ($rose(o_rx_link_clock_out));
  cov_irq_drive: cover property ($rose(o_irq_n_oe));
endmodule : e1n_natbits_chk

bind e1n_natbits e1n_natbits_chk e1n_natbits_chk_i (.i_clk, .i_sys_rst, .i_cs, .i_wr, .i_rd,
  .o_rdata, .i_force_all_ones_n, .o_irq_n_out, .o_irq_n_oe, .i_tx_bit_strobe,
  .o_tx_line_data, .o_tx_link_clock_out, .o_rx_link_clock_out);

// >>> verif/e1n_natbits_tb_top.sv
// self-checking bench for the national bit block and its link controller model
`timescale 1ns/100ps
module e1n_natbits_tb_top
  import e1n_pkg::*;
;
  localparam logic [7:0]  SA6_PAT = 8'hA5;
  localparam logic [7:0]  SA7_PAT = 8'h3C;
  localparam logic [7:0]  MF_PAT = 8'h2F;
  localparam logic [39:0] TX_BYTES = {8'hFF, 8'h00, SA6_PAT, SA7_PAT, 8'h00};
  logic        i_clk = 1'b0;
  logic        i_sys_rst = 1'b1;
  logic        i_cs = 1'b0;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic [4:0]  i_addr = 5'h00;
  logic [7:0]  i_wdata = 8'h00;
  logic        i_force_all_ones_n = 1'b0;
  logic        i_tx_bit_strobe = 1'b0;
  logic        i_rx_line_clk = 1'b0;
  logic        i_rx_line_data = 1'b1;
  logic        i_rx_mf_sync = 1'b0;
  logic        clear = 1'b0;
  logic [7:0]  o_rdata;
  logic        o_irq_n_out;
  logic        o_irq_n_oe;
  logic        o_tx_line_data;
  logic        tx_link_data;
  logic        o_tx_link_clock_out;
  logic        o_rx_link_data_out;
  logic        o_rx_link_clock_out;
  int          rx_pulses;
  int          rx_ones;
  int          n_mismatch = 0;
  int          checked = 0;
  logic [11:0] tpos = 12'h000;
  logic [11:0] rpos = 12'h000;
  logic [7:0]  v;
  logic        sa8_one = 1'b0;

  e1n_natbits e1n_natbits_i (.i_clk, .i_sys_rst, .i_cs, .i_wr, .i_rd, .i_addr, .i_wdata,
    .o_rdata, .i_force_all_ones_n, .o_irq_n_out, .o_irq_n_oe, .i_tx_bit_strobe,
    .i_backplane_data_in(1'b1), .o_tx_line_data, .i_tx_link_data_in(tx_link_data),
    .o_tx_link_clock_out, .i_rx_line_clk, .i_rx_line_data, .i_rx_mf_sync,
    .o_rx_link_data_out, .o_rx_link_clock_out);
  e1n_link_ctl_model e1n_link_ctl_model_i (.i_clk, .i_sys_rst, .i_clear(clear),
    .i_tx_link_clock_out(o_tx_link_clock_out), .o_tx_link_data_in(tx_link_data),
    .i_rx_link_clock_out(o_rx_link_clock_out), .i_rx_link_data_out(o_rx_link_data_out),
    .o_rx_pulses(rx_pulses), .o_rx_ones(rx_ones));

  always #5 i_clk = ~i_clk;

  // received line, 10-cycle bits: zero only in the sa4 and sa8 cells of odd frames
  initial
  begin
    @(negedge i_sys_rst);
    @(posedge i_clk);
    forever
    begin
      i_rx_mf_sync <= (rpos == 12'h000);
      i_rx_line_data <= !(rpos[8] && (rpos[7:0] == 8'h03 || (rpos[7:0] == 8'h07 && !sa8_one)));
      repeat (5) @(posedge i_clk);
      i_rx_line_clk <= 1'b1;
      repeat (5) @(posedge i_clk);
      i_rx_line_clk <= 1'b0;
      rpos = rpos + 12'h001;
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic reg_wr(input logic [4:0] a, input logic [7:0] d);
    i_cs <= 1'b1;
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_cs <= 1'b0;
    i_wr <= 1'b0;
    @(posedge i_clk);
  endtask : reg_wr

  task automatic reg_rd(input logic [4:0] a, output logic [7:0] d);
    i_cs <= 1'b1;
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_cs <= 1'b0;
    i_rd <= 1'b0;
    repeat (2) @(posedge i_clk);
    d = o_rdata;
  endtask : reg_rd

  // odd frames: multiframe bit, 1, alarm 0, link 0, transparent 1, buffers, link 1
  function automatic logic [7:0] exp_ts0(input logic [3:0] f, input logic forced);
    logic [2:0] k;
    k = 3'h7 - f[3:1];
    if (forced)
      return 8'hFF;
    if (!f[0])
      return 8'h9B;
    return {MF_PAT[k], 1'b1, 1'b0, 1'b0, 1'b1, SA6_PAT[k], SA7_PAT[k], 1'b1};
  endfunction : exp_ts0

  // one multiframe of strobes; slow inside timeslot zero so link pulses fit
  task automatic run_mf(input logic forced, input logic judge);
    logic [7:0] got;
    for (int i = 0; i < 4096; i++)
    begin
      i_tx_bit_strobe <= 1'b1;
      @(posedge i_clk);
      i_tx_bit_strobe <= 1'b0;
      repeat ((tpos[7:3] == 5'h00) ? 40 : 2) @(posedge i_clk);
      got = {got[6:0], o_tx_line_data};
      if (judge && tpos[7:0] == 8'h07)
        check(got, exp_ts0(tpos[11:8], forced));
      tpos = tpos + 12'h001;
    end
  endtask : run_mf

  task automatic test_forced();
    run_mf(1'b1, 1'b1);
    check({7'h00, o_irq_n_oe}, 8'h00);
  endtask : test_forced

  task automatic test_registers();
    reg_wr(5'h00, PAGE_TX_NATBITS);
    reg_rd(OFS_NATBITS_0, v);
    check(v, RST_NATBITS);
    for (int i = 0; i < 5; i++)
      reg_wr(OFS_NATBITS_0 + 5'(i), TX_BYTES[39 - 8 * i -: 8]);
    for (int i = 0; i < 5; i++)
    begin
      reg_rd(OFS_NATBITS_0 + 5'(i), v);
      check(v, TX_BYTES[39 - 8 * i -: 8]);
    end
    reg_wr(5'h00, PAGE_RX_NATBITS);
    reg_wr(5'h14, 8'h55);
    reg_wr(5'h00, PAGE_MASTER_CTL);
    reg_rd(OFS_LINK_SEL, v);
    check(v, RST_SELECT);
    reg_wr(OFS_LINK_SEL, 8'hF1);
    reg_rd(OFS_LINK_SEL, v);
    check(v, 8'h11);
    reg_wr(OFS_CH0_TRANSP, 8'h18);
    reg_wr(OFS_IRQ_MASK, 8'h01);
    reg_rd(5'h1F, v);
    check(v, 8'h00);
    repeat (10) @(posedge i_clk);
    check({7'h00, o_irq_n_oe}, 8'h00);
    i_force_all_ones_n <= 1'b1;
    repeat (10) @(posedge i_clk);
    check({7'h00, o_irq_n_oe}, 8'h01);
  endtask : test_registers

  task automatic test_framing();
    run_mf(1'b0, 1'b0);
    clear <= 1'b1;
    @(posedge i_clk);
    clear <= 1'b0;
    run_mf(1'b0, 1'b1);
    check(8'(rx_ones), 8'h00);
    check({7'h00, rx_pulses != 0}, 8'h01);
  endtask : test_framing

  task automatic test_rx_buffer();
    reg_wr(5'h00, PAGE_RX_NATBITS);
    reg_rd(OFS_NATBITS_0, v);
    check(v, 8'h00);
    reg_rd(OFS_NATBITS_0 + 5'h01, v);
    check(v, 8'hFF);
    reg_rd(OFS_NATBITS_0 + 5'h04, v);
    check(v, 8'h00);
    reg_wr(5'h00, PAGE_MASTER_STS);
    reg_rd(OFS_IRQ_STATUS, v);
    check(v & 8'h01, 8'h01);
  endtask : test_rx_buffer

  // sa8 turns from 0 to 1; one multiframe half covers a nibble end
  task automatic test_sa_change();
    reg_wr(5'h00, PAGE_MASTER_CTL);
    reg_wr(OFS_SA_CHG_CTL, 8'h88);
    reg_wr(5'h00, PAGE_MASTER_STS);
    reg_rd(OFS_IRQ_STATUS, v);
    check(v & 8'h06, 8'h00);
    sa8_one <= 1'b1;
    repeat (21000) @(posedge i_clk);
    reg_rd(OFS_IRQ_STATUS, v);
    check(v & 8'h06, 8'h06);
  endtask : test_sa_change

  task automatic finish_test();
    $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : finish_test

  // main sequence
  initial
  begin
    repeat (5) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    @(posedge i_clk);
    test_forced();
    test_registers();
    test_framing();
    test_rx_buffer();
    test_sa_change();
    finish_test();
  end

  // watchdog well past the roughly 73k cycles the tests take
  initial
  begin
    #1000000;
    n_mismatch++;
    finish_test();
  end
endmodule : e1n_natbits_tb_top
